// File: src/cgc_defines.svh
// Function
// [RULE1] Source field 00 picks loop output, 01 internal ref, 10 external ref.
// [RULE2] Reserved source code 11 behaves exactly like code 00.
// [RULE3] Reference divider divides by two to the field value, reset 000.
// [RULE4] Software keeps divided reference inside the loop's allowed input range.
// [RULE5] Internal reference select 1 feeds internal ref, 0 external ref.
// [RULE6] Internal ref output enable turns internal clock output on or off.
// [RULE7] Internal ref runs in stop if enabled and output on or internal mode.
// [RULE8] Bus divider divides selected source by 1, 2, 4 or 8, reset 01.
// [RULE9] Range bit selects high or low external frequency range.
// [RULE10] Gain bit selects high gain or low power oscillator operation.
// [RULE11] Low power bit disables the loop while a bypassed mode is active.
// [RULE12] Type bit requests crystal oscillator or direct external clock.
// [RULE13] External ref output enable turns external clock output on or off.
// [RULE14] External ref runs in stop if enabled and output on or external mode.
// [RULE15] Internal reference status follows select bit only after synchronising.
// [RULE16] Select or divider change clears lock until the loop relocks.
// [RULE17] Both control registers are 8-bit read and write.
// [RULE18] Divided reference feeds whichever loop is currently selected.
`ifndef CGC_DEFINES_SVH
`define CGC_DEFINES_SVH
`define CGC_OFS_CTRL_ONE   8'h00
`define CGC_OFS_CTRL_TWO   8'h04
`define CGC_OFS_STATUS     8'h08
`define CGC_OFS_MODE       8'h0C
`define CGC_RST_CTRL_ONE   8'h04
`define CGC_RST_CTRL_TWO   8'h40
`define CGC_F_SRC_HI       7
`define CGC_F_SRC_LO       6
`define CGC_F_REFERENCE_DIVIDER_HI      5
`define CGC_F_REFERENCE_DIVIDER_LO      3
`define CGC_F_IREF_SEL     2
`define CGC_F_IREF_OE      1
`define CGC_F_IREF_STEN    0
`define CGC_F_BUS_DIVIDER_HI      7
`define CGC_F_BUS_DIVIDER_LO      6
`define CGC_F_RANGE        5
`define CGC_F_HGO          4
`define CGC_F_LP           3
`define CGC_F_EREF_TYPE    2
`define CGC_F_EREF_OE      1
`define CGC_F_EREF_STEN    0
`endif

// File: src/cgc_pkg.sv
package cgc_pkg;
   // System clock source codes.
   typedef enum logic [1:0]
   {
      CGC_SRC_LOOP = 2'h0,
      CGC_SRC_IREF = 2'h1,
      CGC_SRC_EREF = 2'h2,
      CGC_SRC_RSVD = 2'h3
   } cgc_src_e;
   typedef logic [7:0] cgc_byte_t;
endpackage

// File: src/cgc_clock_gen_ctrl.sv
// Implementation choices: the address map and register access over AHB-Lite.
`include "cgc_defines.svh"

module cgc_clock_gen_ctrl
(
   // Bus clock and reset.
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // AHB-Lite slave.
   input  wire logic             hsel,
   input  wire logic [7:0]       haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   // Clock tree inputs, asynchronous to hclk.
   input  wire logic             stop_req,
   input  wire logic             loop_locked,
   // Clock tree controls.
   output cgc_pkg::cgc_src_e     sys_clock_source_sel,
   output logic      [7:0]       ref_div_ratio,
   output logic      [3:0]       bus_div_ratio,
   output logic                  ref_from_internal,
   output logic                  ref_to_pll,
   output logic                  internal_ref_clock_out_en,
   output logic                  external_ref_clock_out_en,
   output logic                  internal_ref_run,
   output logic                  external_ref_run,
   output logic                  osc_high_range,
   output logic                  osc_high_gain_select,
   output logic                  ext_ref_type_select,
   output logic                  loop_enable,
   output logic                  internal_ref_status,
   output logic                  lock_indication
);
   import cgc_pkg::*;

   // Every check in this module samples on the bus clock and rests in reset.
   default clocking chk_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   ////////////////////////////////////////////////////////////////////////
   // Bus slave.
   logic [7:0]  ctrl_one_q;
   logic [7:0]  ctrl_two_q;
   logic        pll_sel_q;
   logic [7:0]  wr_addr_q;
   logic        wr_pend_q;
   logic [31:0] rdata_d;

   wire         bus_go   = hsel & hready & htrans[1];
   wire         wr_one   = wr_pend_q & (wr_addr_q == `CGC_OFS_CTRL_ONE);
   wire         wr_two   = wr_pend_q & (wr_addr_q == `CGC_OFS_CTRL_TWO);
   wire         wr_mode  = wr_pend_q & (wr_addr_q == `CGC_OFS_MODE);
   wire [7:0]   wbyte    = hwdata[7:0];

   // A read right behind a write to the same register must see the new
   // byte, so the read mux looks through a write still in its data phase.
   wire [7:0]   ctrl_one_d = wr_one ? wbyte : ctrl_one_q;
   wire [7:0]   ctrl_two_d = wr_two ? wbyte : ctrl_two_q;
   wire         pll_sel_d  = wr_mode ? wbyte[0] : pll_sel_q;

   // Zero wait states; unmapped reads give zero and writes are dropped.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Write address is captured, data taken in the following data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= bus_go & hwrite;
         wr_addr_q <= haddr;
      end
   end

   // Control registers keep whatever software last wrote.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_one_q <= `CGC_RST_CTRL_ONE;
         ctrl_two_q <= `CGC_RST_CTRL_TWO;
         pll_sel_q  <= 1'b0;
      end
      else
      begin
         if (wr_one)
            ctrl_one_q <= wbyte; // RULE17
         if (wr_two)
            ctrl_two_q <= wbyte; // RULE17
         if (wr_mode)
            pll_sel_q <= wbyte[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field decode.
   wire [1:0] src_raw   = ctrl_one_q[`CGC_F_SRC_HI:`CGC_F_SRC_LO];
   wire [2:0] reference_divider      = ctrl_one_q[`CGC_F_REFERENCE_DIVIDER_HI:`CGC_F_REFERENCE_DIVIDER_LO];
   wire       iref_sel  = ctrl_one_q[`CGC_F_IREF_SEL];
   wire       iref_oe   = ctrl_one_q[`CGC_F_IREF_OE];
   wire       iref_sten = ctrl_one_q[`CGC_F_IREF_STEN];
   wire [1:0] bus_divider      = ctrl_two_q[`CGC_F_BUS_DIVIDER_HI:`CGC_F_BUS_DIVIDER_LO];
   wire       lp        = ctrl_two_q[`CGC_F_LP];
   wire       eref_oe   = ctrl_two_q[`CGC_F_EREF_OE];
   wire       eref_sten = ctrl_two_q[`CGC_F_EREF_STEN];

   // Reserved code falls back to the loop output.
   assign sys_clock_source_sel = (src_raw == CGC_SRC_RSVD) ? CGC_SRC_LOOP
                                 : cgc_src_e'(src_raw); // RULE1 RULE2
   assign ref_div_ratio   = 8'h01 << reference_divider;      // RULE3
   assign bus_div_ratio   = 4'h1 << bus_divider;       // RULE8
   assign ref_from_internal = iref_sel;         // RULE5
   assign ref_to_pll      = pll_sel_q;          // RULE18
   assign osc_high_range  = ctrl_two_q[`CGC_F_RANGE];     // RULE9
   assign osc_high_gain_select = ctrl_two_q[`CGC_F_HGO];  // RULE10
   assign ext_ref_type_select = ctrl_two_q[`CGC_F_EREF_TYPE]; // RULE12

   ////////////////////////////////////////////////////////////////////////
   // Pin and select bit synchronisers.
   logic [1:0] stop_s_q;
   logic [1:0] lock_s_q;
   logic [1:0] internal_ref_status_s_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stop_s_q   <= 2'h0;
         lock_s_q   <= 2'h0;
         internal_ref_status_s_q <= 2'h3;
      end
      else
      begin
         stop_s_q   <= {stop_s_q[0], stop_req};
         lock_s_q   <= {lock_s_q[0], loop_locked};
         internal_ref_status_s_q <= {internal_ref_status_s_q[0], iref_sel}; // RULE15
      end
   end
   wire stop_now = stop_s_q[1];
   wire lock_now = lock_s_q[1];
   assign internal_ref_status = internal_ref_status_s_q[1]; // RULE15

   ////////////////////////////////////////////////////////////////////////
   // Mode and stop behaviour.
   wire bypassed = (sys_clock_source_sel != CGC_SRC_LOOP);
   wire int_mode = iref_sel & (sys_clock_source_sel != CGC_SRC_EREF);
   wire ext_mode = ~iref_sel & (sys_clock_source_sel != CGC_SRC_IREF);
   logic int_mode_q;
   logic ext_mode_q;

   // Mode is frozen on stop entry so stop keeps the pre-stop decision.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         int_mode_q <= 1'b1;
         ext_mode_q <= 1'b0;
      end
      else if (!stop_now)
      begin
         int_mode_q <= int_mode;
         ext_mode_q <= ext_mode;
      end
   end

   // An output clock lives only while its reference runs, so in stop the
   // stop enable decides whether peripherals keep their clock.
   assign internal_ref_clock_out_en = iref_oe & internal_ref_run; // RULE6
   assign external_ref_clock_out_en = eref_oe & external_ref_run; // RULE13
   assign internal_ref_run = stop_now
      ? (iref_sten & (iref_oe | int_mode_q)) : 1'b1;          // RULE7
   assign external_ref_run = stop_now
      ? (eref_sten & (eref_oe | ext_mode_q))
      : (ext_mode | eref_oe);                                 // RULE14
   assign loop_enable = ~stop_now & ~(lp & bypassed);         // RULE11

   ////////////////////////////////////////////////////////////////////////
   // Lock indication, cleared on reference change until relock.
   logic [3:0] ref_cfg_q;
   logic       lock_q;
   logic       relock_wait_q;
   wire        ref_change = (ref_cfg_q != {iref_sel, reference_divider});
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ref_cfg_q     <= 4'h8;
         lock_q        <= 1'b0;
         relock_wait_q <= 1'b0;
      end
      else
      begin
         ref_cfg_q <= {iref_sel, reference_divider};
         if (ref_change | ~loop_enable)
         begin
            lock_q        <= 1'b0; // RULE16
            relock_wait_q <= 1'b1;
         end
         else if (relock_wait_q)
            relock_wait_q <= lock_now;  // Wait for loss then regain.
         else
            lock_q <= lock_now;
      end
   end
   assign lock_indication = lock_q;

   ////////////////////////////////////////////////////////////////////////
   // Read mux, registered in the data phase.
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (haddr == `CGC_OFS_CTRL_ONE)
         rdata_d[7:0] = ctrl_one_d;
      else if (haddr == `CGC_OFS_CTRL_TWO)
         rdata_d[7:0] = ctrl_two_d;
      else if (haddr == `CGC_OFS_STATUS)
         rdata_d[1:0] = {lock_q, internal_ref_status_s_q[1]};
      else if (haddr == `CGC_OFS_MODE)
         rdata_d[0] = pll_sel_d;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (bus_go & ~hwrite)
         hrdata <= rdata_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks, on the bus clock with the defaults declared at the top.

   // The reserved source code must never reach the clock mux as such.
   chk_reserved_src: assert property // RULE2
      (src_raw == CGC_SRC_RSVD |-> sys_clock_source_sel == CGC_SRC_LOOP)
      else $error("reserved source not mapped to loop");

   // Legal source codes pass straight through to the clock mux.
   chk_src_select: assert property // RULE1
      (src_raw != CGC_SRC_RSVD |-> sys_clock_source_sel == src_raw)
      else $error("source select wrong");

   // Exactly one ratio bit, at the place that the divider field names.
   chk_ref_div: assert property // RULE3
      ($onehot(ref_div_ratio) && ref_div_ratio[reference_divider])
      else $error("reference divide wrong");

   // The bus divider is a power of two as well, never a blend of two.
   chk_bus_div: assert property // RULE8
      ($onehot(bus_div_ratio) && bus_div_ratio[bus_divider])
      else $error("bus divide wrong");

   // Outside stop the internal output follows its enable bit alone.
   chk_iref_out: assert property // RULE6
      (!stop_now |-> internal_ref_clock_out_en == iref_oe)
      else $error("internal output enable wrong");

   // Outside stop the external output follows its enable bit alone.
   chk_eref_out: assert property // RULE13
      (!stop_now |-> external_ref_clock_out_en == eref_oe)
      else $error("external output enable wrong");

   // The status bit lags the select bit by the two synchroniser stages.
   chk_iref_sync: assert property // RULE15
      ($changed(iref_sel) |=> ##1 internal_ref_status == $past(iref_sel, 2))
      else $error("status not synchronised");

   // Without its stop enable the internal reference must halt in stop.
   chk_iref_stop: assert property // RULE7
      (stop_now && !iref_sten |-> !internal_ref_run)
      else $error("internal ref running in stop");

   // With its stop enable set, a peripheral that asked for the internal clock keeps it in stop.
   chk_iref_keep: assert property // RULE7
      (stop_now && iref_sten && iref_oe |-> internal_ref_run)
      else $error("internal ref stopped");

   // With its stop enable set, a peripheral that asked for the external clock keeps it in stop.
   chk_eref_stop: assert property // RULE14
      (stop_now && eref_sten && eref_oe |-> external_ref_run)
      else $error("external ref stopped");

   // Without its stop enable the external reference must halt in stop.
   chk_eref_off: assert property // RULE14
      (stop_now && !eref_sten |-> !external_ref_run)
      else $error("external ref running in stop");

   // Low power bypass saves the loop's current while it is not used.
   chk_lp_bypass: assert property // RULE11
      (lp && bypassed |-> !loop_enable)
      else $error("loop running in low power bypass");

   // Outside stop, with low power off the loop keeps running, bypassed or not.
   chk_loop_run: assert property // RULE11
      (!stop_now && !lp |-> loop_enable)
      else $error("loop stopped outside low power");

   // A new reference setting drops the lock flag on the next clock edge.
   chk_lock_clear: assert property // RULE16
      (ref_change |=> !lock_indication)
      else $error("lock not cleared");

   // A stale lock must not show while the loop still has to relock.
   chk_lock_hold: assert property // RULE16
      (relock_wait_q |-> !lock_indication)
      else $error("lock shown before relock");

   // A write to control one lands in the cycle after its data phase.
   chk_write_one: assert property // RULE17
      (wr_one |=> ctrl_one_q == $past(wbyte))
      else $error("control one write lost");

   // A write to control two lands in the cycle after its data phase.
   chk_write_two: assert property // RULE17
      (wr_two |=> ctrl_two_q == $past(wbyte))
      else $error("control two write lost");

   // Only the low byte carries register bits; the rest reads zero.
   chk_read_upper: assert property // RULE17
      (hrdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");

   // The slave never stalls and never answers with an error.
   chk_bus_okay: assert property // RULE17
      (hreadyout && !hresp)
      else $error("bus response not okay");

   // The loop select written by software steers the divided reference.
   chk_pll_route: assert property // RULE18
      (wr_mode |=> ref_to_pll == $past(wbyte[0]))
      else $error("reference not routed to chosen loop");

   // Scenarios worth seeing: a write, stop with the internal reference
   // kept alive, a relock and the reserved source code.
   cov_write: cover property (wr_two);
   cov_stop: cover property (stop_now && internal_ref_run);
   cov_relock: cover property ($rose(lock_indication));
   cov_reserved: cover property (src_raw == CGC_SRC_RSVD);
endmodule

// File: test/tb.sv
`include "cgc_defines.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cgc_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd, r;
   logic        hreadyout, hresp;
   logic        stop_req = 1'b0;
   logic        loop_locked = 1'b0;
   cgc_src_e    src;
   logic [7:0]  rdr, c1, c2;
   logic [3:0]  bdr;
   logic        xr;
   logic        rfi, rtp, ioe, eoe, irun, erun, ohr, ohg, ert, len, irs, lck;
   int          miscompares = 0;
   int          checked = 0;
   int          cyc = 0;

   // The slave's own ready is the bus ready, as with a single slave.
   cgc_clock_gen_ctrl u_dut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .stop_req(stop_req), .loop_locked(loop_locked),
      .sys_clock_source_sel(src), .ref_div_ratio(rdr), .bus_div_ratio(bdr),
      .ref_from_internal(rfi), .ref_to_pll(rtp),
      .internal_ref_clock_out_en(ioe), .external_ref_clock_out_en(eoe),
      .internal_ref_run(irun), .external_ref_run(erun),
      .osc_high_range(ohr), .osc_high_gain_select(ohg),
      .ext_ref_type_select(ert), .loop_enable(len),
      .internal_ref_status(irs), .lock_indication(lck)
   );

   // A 40 MHz clock.
   always #12.5 hclk = ~hclk;

   ////////////////////////////////////////////////////////////////////////
   // Verdict in one place, so a hang and a normal end report alike.
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Cut a hang short; the whole run needs far fewer cycles.
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         end_sim();
      end
   end

   // Case equality, so an unknown never passes for a match.
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // One single AHB-Lite transfer; the master waits for ready each phase.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      #1;
   endtask

   // Let edges pass, then step off the edge so updates have landed.
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // The reserved source code falls back to the loop output.
   function automatic logic [1:0] exp_src(input logic [7:0] a);
      return (a[7:6] == 2'h3) ? 2'h0 : a[7:6];
   endfunction

   // Outside stop, the loop stops only in low power while a bypassed source is chosen.
   function automatic logic exp_loop(input logic [7:0] a, input logic [7:0] b);
      return !(b[3] && (a[7:6] == 2'h1 || a[7:6] == 2'h2));
   endfunction

   // Internal modes run from the internal reference off a non-external
   // source; external modes from the external one off a non-internal one.
   function automatic logic int_md(input logic [7:0] a);
      return a[2] && exp_src(a) != 2'h2;
   endfunction
   function automatic logic ext_md(input logic [7:0] a);
      return !a[2] && exp_src(a) != 2'h1;
   endfunction

   // Every static control output against both register values.
   task automatic cfg(input logic [7:0] a, input logic [7:0] b);
      chk("source", {30'h0, exp_src(a)}, {30'h0, src});
      chk("ref div", 32'h1 << a[5:3], {24'h0, rdr});
      chk("ref internal", {31'h0, a[2]}, {31'h0, rfi});
      chk("int out en", {31'h0, a[1]}, {31'h0, ioe});
      chk("bus div", 32'h1 << b[7:6], {28'h0, bdr});
      chk("high range", {31'h0, b[5]}, {31'h0, ohr});
      chk("high gain", {31'h0, b[4]}, {31'h0, ohg});
      chk("loop enable", {31'h0, exp_loop(a, b)}, {31'h0, len});
      chk("ext type", {31'h0, b[2]}, {31'h0, ert});
      chk("ext out en", {31'h0, b[1]}, {31'h0, eoe});
      chk("int run", 32'h1, {31'h0, irun});
      chk("ext run", {31'h0, ext_md(a) | b[1]}, {31'h0, erun});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      r = $urandom(32'h0cdea1dc);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, `CGC_OFS_CTRL_ONE, 32'h0, rd);
      chk("ctrl one reset", 32'h04, rd);
      bus(1'b0, `CGC_OFS_CTRL_TWO, 32'h0, rd);
      chk("ctrl two reset", 32'h40, rd);
      cfg(8'h04, 8'h40);
      // Every source and divider code, with random other bits.
      for (int i = 0; i < 32; i++)
      begin
         r = $urandom;
         c1 = {i[4:0], r[2:0]};
         c2 = r[15:8];
         bus(1'b1, `CGC_OFS_CTRL_ONE, {24'h0, c1}, rd);
         bus(1'b1, `CGC_OFS_CTRL_TWO, {24'h0, c2}, rd);
         bus(1'b0, `CGC_OFS_CTRL_ONE, 32'h0, rd);
         chk("ctrl one", {24'h0, c1}, rd);
         bus(1'b0, `CGC_OFS_CTRL_TWO, 32'h0, rd);
         chk("ctrl two", {24'h0, c2}, rd);
         cfg(c1, c2);
         @(posedge hclk) stop_req <= 1'b1;
         wt(4);
         xr = c1[1] & c1[0];
         chk("int out en stop", {31'h0, xr}, {31'h0, ioe});
         xr = c2[1] & c2[0];
         chk("ext out en stop", {31'h0, xr}, {31'h0, eoe});
         xr = c1[0] & (c1[1] | int_md(c1));
         chk("int run", {31'h0, xr}, {31'h0, irun});
         xr = c2[0] & (c2[1] | ext_md(c1));
         chk("ext run", {31'h0, xr}, {31'h0, erun});
         @(posedge hclk) stop_req <= 1'b0;
         wt(4);
      end
      // Lock is lost on a divider change and held off until relock.
      bus(1'b1, `CGC_OFS_CTRL_TWO, 32'h40, rd);
      bus(1'b1, `CGC_OFS_CTRL_ONE, 32'h04, rd);
      @(posedge hclk) loop_locked <= 1'b1;
      wt(6);
      chk("lock", 32'h1, {31'h0, lck});
      bus(1'b1, `CGC_OFS_CTRL_ONE, 32'h0C, rd);
      wt(6);
      chk("lock after change", 32'h0, {31'h0, lck});
      @(posedge hclk) loop_locked <= 1'b0;
      wt(4);
      @(posedge hclk) loop_locked <= 1'b1;
      wt(6);
      chk("relock", 32'h1, {31'h0, lck});
      bus(1'b0, `CGC_OFS_STATUS, 32'h0, rd);
      chk("status reg", 32'h3, rd);
      // Status lags the select bit by the synchroniser.
      bus(1'b1, `CGC_OFS_CTRL_ONE, 32'h08, rd);
      chk("status early", 32'h1, {31'h0, irs});
      wt(4);
      chk("status late", 32'h0, {31'h0, irs});
      bus(1'b1, `CGC_OFS_MODE, 32'h1, rd);
      chk("to pll", 32'h1, {31'h0, rtp});
      bus(1'b0, `CGC_OFS_MODE, 32'h0, rd);
      chk("mode reg", 32'h1, rd);
      bus(1'b1, `CGC_OFS_MODE, 32'h0, rd);
      chk("to fll", 32'h0, {31'h0, rtp});
      // An unmapped place reads zero and leaves control one alone.
      bus(1'b1, 8'h10, 32'hFF, rd);
      bus(1'b0, 8'h10, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, `CGC_OFS_CTRL_ONE, 32'h0, rd);
      chk("ctrl one kept", 32'h08, rd);
      chk("response", 32'h0, {31'h0, hresp});
      end_sim();
   end
endmodule
